/* rtl/ddr_cmd_map.svh */
// Constants of the command interface: widths, mode fields, timing counts.
// Included by the bank and device design files and the test files; holds definitions only.
`ifndef DDR_CMD_MAP_SVH
`define DDR_CMD_MAP_SVH

`define BANKS 8
`define BANK_BITS 3
`define ADDR_BITS 11
`define COL_BITS 7
`define LANES 4
`define MODE_BITS 10

// Mode word fields, taken from ADDRESS[9:0] at a mode load
`define MODE_A10 10
`define MODE_BL_LSB 0
`define MODE_CL_LSB 4
`define MODE_EXT_SEL 0
`define MODE_RESET 10'h032
`define EXT_RESET 10'h000

// Delays in link clock cycles, each at least 2
`define RCD_CYCLES 3
`define RSC_CYCLES 2
`define REFC_CYCLES 8
`define LOCK_CYCLES 16
`define PDE_CYCLES 2

`endif

/* rtl/ddr_cmd_pkg.sv */
// Types shared by the command interface modules.
// Assumes nothing of its surroundings.
`default_nettype none

package ddr_cmd_pkg;

   typedef enum logic [3:0] {
      CMD_NOP, CMD_RESERVED, CMD_READ, CMD_WRITE, CMD_OPEN,
      CMD_CLOSE, CMD_CLOSE_ALL, CMD_REFRESH, CMD_MODE
   } cmd_type;

   typedef enum {
      ST_RUN, ST_MODE_WAIT, ST_REFRESH, ST_SELF, ST_SELF_EXIT,
      ST_SLEEP, ST_SLEEP_EXIT
   } dev_state_type;

   typedef enum {
      BANK_IDLE, BANK_OPENING, BANK_ACTIVE, BANK_BURST, BANK_BURST_CLOSE
   } bank_state_type;

endpackage

`default_nettype wire

/* rtl/sync_level.sv */
// Two-stage synchroniser for independent level signals.
// Assumes each bit is glitch-free in its source domain.
`default_nettype none

module sync_level #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

`default_nettype wire

/* rtl/bank_fsm.sv */
// State of one bank: idle, opening, active, burst, burst with close.
// Assumes requests are one-cycle pulses on the link clock.
`include "ddr_cmd_map.svh"
`default_nettype none

module bank_fsm
   import ddr_cmd_pkg::*;
#(
   parameter int RCD = `RCD_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic open_req,
   input wire logic close_req,
   input wire logic burst_req,
   input wire logic burst_auto,
   input wire logic burst_end,
   output logic is_idle,
   output logic is_active
);
   bank_state_type state, next_state;
   logic [7:0] count, next_count;

   always_comb begin
      next_state = state;
      next_count = count;
      unique case (state)
         BANK_IDLE: begin
            if (open_req) begin
               next_state = BANK_OPENING;
               next_count = 8'(RCD - 1);
            end
         end
         BANK_OPENING: begin
            // Active one edge early so a column command at RCD sees it
            if (count <= 8'h01) begin
               next_state = BANK_ACTIVE;
            end else begin
               next_count = count - 8'h01;
            end
         end
         BANK_ACTIVE: begin
            if (close_req) begin
               next_state = BANK_IDLE;
            end else if (burst_req) begin
               next_state = burst_auto ? BANK_BURST_CLOSE : BANK_BURST;
            end
         end
         BANK_BURST: begin
            if (burst_end) begin
               next_state = BANK_ACTIVE;
            end
         end
         BANK_BURST_CLOSE: begin
            if (burst_end) begin
               next_state = BANK_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= BANK_IDLE;
         count <= 8'h00;
         is_idle <= 1'b1;
         is_active <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         is_idle <= (next_state == BANK_IDLE);
         is_active <= (next_state == BANK_ACTIVE);
      end
   end
endmodule

`default_nettype wire

/* rtl/ddr_cmd_device.sv */
// Command interface of an eight-bank 32-bit DRAM, device side.
// Assumes a controller clocking commands on LINK_CLK; status to REF_CLK.
// Operation
// - All command pins sampled at rising link edge
// - Deselect and no-operation behave identically
// - Column command in active bank starts burst
// - Close command closes the selected bank
// - Close with auto-close closes all banks
// - All strobes low with auto-close low and address bit 10 low loads mode registers
// - Masked byte lanes are not written
// - Refresh pattern refreshes, or enters self-refresh
// - Opened bank becomes active after delay
// - Mode load recovers, only no-ops meanwhile
// - Plain burst ends, bank returns active
// - Auto-close burst ends, bank becomes idle
// - Write data taken latency minus one later
// - Burst length and latency 2 or 3 programmable
// - Self-refresh exit, idle after lock delay
// - Power-down exit delay; no sleep in bursts
`include "ddr_cmd_map.svh"
`default_nettype none

module ddr_cmd_device
   import ddr_cmd_pkg::*;
#(
   parameter int RCD = `RCD_CYCLES,
   parameter int RSC = `RSC_CYCLES,
   parameter int REFC = `REFC_CYCLES,
   parameter int LOCK = `LOCK_CYCLES,
   parameter int PDE = `PDE_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic LINK_CLK,
   input wire logic SLEEP,
   input wire logic CHIP_SELECT_N,
   input wire logic ROW_STROBE_N,
   input wire logic COLUMN_STROBE_N,
   input wire logic WRITE_ENABLE_N,
   input wire logic AUTO_CLOSE,
   input wire logic [`BANK_BITS-1:0] ARRAY_SEL,
   input wire logic [`ADDR_BITS-1:0] ADDRESS,
   input wire logic [`LANES-1:0] BYTE_MASK,
   input wire logic [31:0] DATA_IN,
   output logic [31:0] DATA_OUT,
   output logic DATA_OE_N,
   output logic [`LANES-1:0] DATA_STROBE_OUT,
   output logic DATA_STROBE_OE_N,
   output logic [`MODE_BITS-1:0] MODE_VALUE,
   output logic [`MODE_BITS-1:0] EXT_MODE_VALUE,
   output logic [`BANKS-1:0] BANK_OPEN,
   output logic SELF_REFRESH,
   output logic POWER_DOWN,
   output logic PROTOCOL_ERROR
);
   localparam int MEM_BITS = `BANK_BITS + `COL_BITS;
   localparam int RCD_M1 = RCD - 1;

   logic rst_meta, rst_link;
   cmd_type cmd;
   logic exec, start, mode_go, all_idle, bad, xfer, xfer_last;
   logic [`BANKS-1:0] bank_idle, bank_active;
   logic [`BANKS-1:0] open_req, close_req, burst_req, burst_end;
   logic [`LANES-1:0] wr_lane;
   logic [MEM_BITS-1:0] mem_addr, prev_addr;
   logic [31:0] rd_word;
   logic [2:0] lat_load;
   logic [3:0] blen;

   dev_state_type state, next_state;
   logic [7:0] count, next_count;
   logic sleep_prev, err, next_err;
   logic [`MODE_BITS-1:0] next_mode, next_ext;
   logic busy, next_busy, bst_write, next_write, bst_close, next_close;
   logic [2:0] lat_left, next_lat;
   logic [3:0] beat_left, next_beat;
   logic [`BANK_BITS-1:0] bst_bank, next_bank;
   logic [`COL_BITS-1:0] bst_col, next_col;
   logic [31:0] next_dq;
   logic next_oe_n, dqs, next_dqs;
   logic [2:0] status, next_status;

   // Reset leaves the link domain only on a link clock edge
   always_ff @(posedge LINK_CLK or posedge RESET) begin
      if (RESET) begin
         rst_meta <= 1'b1;
         rst_link <= 1'b1;
      end else begin
         rst_meta <= 1'b0;
         rst_link <= rst_meta;
      end
   end

   always_comb begin
      cmd = CMD_NOP;
      if (!CHIP_SELECT_N) begin
         unique case ({ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N})
            3'b111: cmd = CMD_NOP;
            3'b110: cmd = CMD_RESERVED;
            3'b101: cmd = CMD_READ;
            3'b100: cmd = CMD_WRITE;
            3'b011: cmd = CMD_OPEN;
            3'b010: cmd = AUTO_CLOSE ? CMD_CLOSE_ALL : CMD_CLOSE;
            3'b001: cmd = CMD_REFRESH;
            3'b000: begin
               cmd = (!AUTO_CLOSE && !ADDRESS[`MODE_A10]) ?
                     CMD_MODE : CMD_RESERVED;
            end
         endcase
      end
   end

   assign exec = (state == ST_RUN) && sleep_prev && SLEEP;
   assign all_idle = &bank_idle;
   assign start = exec && (cmd == CMD_READ || cmd == CMD_WRITE) &&
                  bank_active[ARRAY_SEL] && !busy;
   assign mode_go = exec && cmd == CMD_MODE && all_idle && !busy;
   assign bad = cmd == CMD_RESERVED || cmd == CMD_REFRESH ||
                ((cmd == CMD_READ || cmd == CMD_WRITE) && !start) ||
                (cmd == CMD_OPEN && !bank_idle[ARRAY_SEL]) ||
                (cmd == CMD_MODE && !mode_go) ||
                (busy && cmd != CMD_NOP);
   assign xfer = busy && lat_left == 3'd1;
   assign xfer_last = xfer && beat_left == 4'd1;
   assign mem_addr = {bst_bank, bst_col};
   // Only latency 3 gives a longer wait; other codes act as 2
   assign lat_load = (MODE_VALUE[`MODE_CL_LSB +: 3] == 3'd3) ?
                     3'd2 : 3'd1;
   assign blen = 4'(1 << MODE_VALUE[`MODE_BL_LSB +: 2]);

   generate
      for (genvar b = 0; b < `BANKS; b++) begin : bank_gen
         assign open_req[b] = exec && cmd == CMD_OPEN &&
                              ARRAY_SEL == `BANK_BITS'(b);
         assign close_req[b] = exec && (cmd == CMD_CLOSE_ALL ||
                               (cmd == CMD_CLOSE &&
                                ARRAY_SEL == `BANK_BITS'(b)));
         assign burst_req[b] = start && ARRAY_SEL == `BANK_BITS'(b);
         assign burst_end[b] = xfer_last &&
                               bst_bank == `BANK_BITS'(b);
         bank_fsm #(.RCD(RCD)) u_bank (
            .clk(LINK_CLK),
            .rst(rst_link),
            .open_req(open_req[b]),
            .close_req(close_req[b]),
            .burst_req(burst_req[b]),
            .burst_auto(AUTO_CLOSE),
            .burst_end(burst_end[b]),
            .is_idle(bank_idle[b]),
            .is_active(bank_active[b])
         );
      end
      for (genvar i = 0; i < `LANES; i++) begin : lane_gen
         logic [7:0] lane_mem [0:(1 << MEM_BITS)-1];
         // Mask counts only with sleep high on the previous edge
         assign wr_lane[i] = xfer && bst_write && sleep_prev &&
                             !BYTE_MASK[i];
         always_ff @(posedge LINK_CLK) begin
            if (wr_lane[i]) begin
               lane_mem[mem_addr] <= DATA_IN[8*i +: 8];
            end
         end
         assign rd_word[8*i +: 8] = lane_mem[mem_addr];
      end
   endgenerate

   always_comb begin
      next_state = state;
      next_count = count;
      next_err = err;
      next_mode = MODE_VALUE;
      next_ext = EXT_MODE_VALUE;
      unique case (state)
         ST_RUN: begin
            if (sleep_prev && cmd == CMD_REFRESH && all_idle && !busy) begin
               next_state = SLEEP ? ST_REFRESH : ST_SELF;
               next_count = 8'(REFC - 1);
            end else if (mode_go) begin
               if (ARRAY_SEL[`MODE_EXT_SEL]) begin
                  next_ext = ADDRESS[`MODE_BITS-1:0];
               end else begin
                  next_mode = ADDRESS[`MODE_BITS-1:0];
               end
               next_state = ST_MODE_WAIT;
               next_count = 8'(RSC - 1);
            end else if (sleep_prev && !SLEEP) begin
               if (cmd == CMD_NOP && all_idle && !busy) begin
                  next_state = ST_SLEEP;
               end else begin
                  next_err = 1'b1;
               end
            end else if (exec && bad) begin
               next_err = 1'b1;
            end
         end
         ST_MODE_WAIT, ST_REFRESH, ST_SELF_EXIT, ST_SLEEP_EXIT: begin
            if (count <= 8'h01) begin
               next_state = ST_RUN;
            end else begin
               next_count = count - 8'h01;
            end
            if (cmd != CMD_NOP || !SLEEP) begin
               next_err = 1'b1;
            end
         end
         ST_SELF: begin
            if (SLEEP) begin
               next_state = ST_SELF_EXIT;
               next_count = 8'(LOCK - 1);
               next_err = err || cmd != CMD_NOP;
            end
         end
         ST_SLEEP: begin
            if (SLEEP) begin
               next_state = ST_SLEEP_EXIT;
               next_count = 8'(PDE - 1);
               next_err = err || cmd != CMD_NOP;
            end
         end
      endcase
      next_status = {next_err, next_state == ST_SLEEP,
                     next_state == ST_SELF};
   end

   always_ff @(posedge LINK_CLK or posedge rst_link) begin
      if (rst_link) begin
         state <= ST_RUN;
         count <= 8'h00;
         sleep_prev <= 1'b1;
         err <= 1'b0;
         MODE_VALUE <= `MODE_RESET;
         EXT_MODE_VALUE <= `EXT_RESET;
         status <= 3'h0;
      end else begin
         state <= next_state;
         count <= next_count;
         sleep_prev <= SLEEP;
         err <= next_err;
         MODE_VALUE <= next_mode;
         EXT_MODE_VALUE <= next_ext;
         status <= next_status;
      end
   end

   always_comb begin
      next_busy = busy;
      next_lat = lat_left;
      next_beat = beat_left;
      next_bank = bst_bank;
      next_col = bst_col;
      next_write = bst_write;
      next_close = bst_close;
      next_dq = DATA_OUT;
      next_oe_n = 1'b1;
      next_dqs = 1'b0;
      if (start) begin
         next_busy = 1'b1;
         next_lat = lat_load;
         next_beat = blen;
         next_bank = ARRAY_SEL;
         next_col = ADDRESS[`COL_BITS-1:0];
         next_write = (cmd == CMD_WRITE);
         next_close = AUTO_CLOSE;
      end else if (busy) begin
         if (!xfer) begin
            next_lat = lat_left - 3'd1;
         end else begin
            next_col = bst_col + `COL_BITS'(1);
            next_beat = beat_left - 4'd1;
            next_busy = !xfer_last;
            if (!bst_write) begin
               // Registered so data stands from edge CL-1 to edge CL
               next_dq = rd_word;
               next_oe_n = 1'b0;
               next_dqs = !dqs;
            end
         end
      end
   end

   always_ff @(posedge LINK_CLK or posedge rst_link) begin
      if (rst_link) begin
         busy <= 1'b0;
         lat_left <= 3'd0;
         beat_left <= 4'd0;
         bst_bank <= '0;
         bst_col <= '0;
         bst_write <= 1'b0;
         bst_close <= 1'b0;
         DATA_OUT <= 32'h0;
         DATA_OE_N <= 1'b1;
         dqs <= 1'b0;
         prev_addr <= '0;
      end else begin
         busy <= next_busy;
         lat_left <= next_lat;
         beat_left <= next_beat;
         bst_bank <= next_bank;
         bst_col <= next_col;
         bst_write <= next_write;
         bst_close <= next_close;
         DATA_OUT <= next_dq;
         DATA_OE_N <= next_oe_n;
         dqs <= next_dqs;
         prev_addr <= mem_addr;
      end
   end

   assign DATA_STROBE_OUT = {`LANES{dqs}};
   assign DATA_STROBE_OE_N = DATA_OE_N;

   sync_level #(.WIDTH(`BANKS + 3)) u_status_sync (
      .clk(REF_CLK),
      .rst(RESET),
      .d({bank_active, status}),
      .q({BANK_OPEN, PROTOCOL_ERROR, POWER_DOWN, SELF_REFRESH})
   );

   default clocking link_cb @(posedge LINK_CLK);
   endclocking
   default disable iff (rst_link);

   a_nop_stays: assert property (
      (exec && cmd == CMD_NOP && !busy) |=> state == ST_RUN && $stable(err))
      else $error("no-operation changed device state");
   // Bank 2 is the bank the scenarios open, close and burst into
   a_open_delay: assert property (
      (open_req[2] && bank_idle[2]) |->
         ##RCD_M1 !bank_active[2] ##1 bank_active[2])
      else $error("bank 2 not active exactly after open delay");
   a_close_one: assert property (
      (close_req[2] && cmd == CMD_CLOSE) |=> !bank_active[2] && bank_idle[2])
      else $error("single close left bank 2 open");
   a_close_all: assert property (
      (exec && cmd == CMD_CLOSE_ALL && !busy) |=> bank_active == 8'h00)
      else $error("all-bank close left a bank active");
   a_mode_recover: assert property (
      mode_go |=> state == ST_MODE_WAIT ##(RSC - 1) state == ST_RUN)
      else $error("mode recovery length wrong");
   a_write_lat: assert property (
      (start && cmd == CMD_WRITE && lat_load == 3'd2) |->
         ##1 !xfer ##1 xfer)
      else $error("write data not taken at latency minus one");
   a_mask_lane: assert property (
      (xfer && bst_write && BYTE_MASK[0]) |=>
         lane_gen[0].lane_mem[prev_addr] == $past(rd_word[7:0]))
      else $error("masked lane 0 was written");
   a_write_lane: assert property (
      (xfer && bst_write && sleep_prev && !BYTE_MASK[1]) |=>
         lane_gen[1].lane_mem[prev_addr] == $past(DATA_IN[15:8]))
      else $error("unmasked lane 1 not written");
   a_plain_end: assert property (
      (xfer_last && !bst_close) |=> bank_active[$past(bst_bank)])
      else $error("plain burst did not return bank to active");
   a_auto_end: assert property (
      (xfer_last && bst_close) |=> bank_idle[$past(bst_bank)])
      else $error("auto-close burst did not idle the bank");
   a_self_hold: assert property (
      (state == ST_SELF && !SLEEP) |=> state == ST_SELF)
      else $error("self-refresh left while sleep low");
   a_self_exit: assert property (
      (state == ST_SELF && SLEEP) |=> state == ST_SELF_EXIT ##[1:300]
         state == ST_RUN)
      else $error("self-refresh exit did not reach idle");

   c_write_burst: cover property (start && cmd == CMD_WRITE ##[1:20] xfer_last);
   c_read_burst: cover property (start && cmd == CMD_READ ##[1:20] !DATA_OE_N);
   c_self_refresh: cover property (state == ST_SELF ##[1:50] state == ST_RUN);
   c_power_down: cover property (state == ST_SLEEP ##[1:50] state == ST_RUN);
endmodule

`default_nettype wire

/* test/ddr_ctl_model.sv */
// Memory controller model: drives commands, masks and write data.
// Assumes the device samples every pin at the rising link clock edge.
`include "ddr_cmd_map.svh"
`default_nettype none

module ddr_ctl_model (
   input wire logic link_clk,
   output logic sleep,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic ac,
   output logic [`BANK_BITS-1:0] ba,
   output logic [`ADDR_BITS-1:0] addr,
   output logic [`LANES-1:0] mask,
   output logic [31:0] wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sleep = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      ac = 1'b0;
      ba = 3'h0;
      addr = 11'h000;
      mask = 4'hF;
      wdata = 32'h0000_0000;
   end

   // One command cycle, then no-operation; address inverted once released
   task automatic cmd(input logic [3:0] pat, input logic a,
         input logic [2:0] b, input logic [10:0] ad, input logic sl);
      @(posedge link_clk);
      {cs_n, ras_n, cas_n, we_n} <= pat;
      ac <= a;
      ba <= b;
      addr <= ad;
      sleep <= sl;
      @(posedge link_clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'h7;
      ba <= ~b;
      addr <= ~ad;
   endtask

   // Called at the store edge; first word lands latency minus one later
   task automatic store_data(input int cl, input logic [31:0] d [4],
         input logic [3:0] m [4]);
      repeat (cl - 2) @(posedge link_clk);
      for (int i = 0; i < 4; i++) begin
         wdata <= d[i];
         mask <= m[i];
         @(posedge link_clk);
      end
      wdata <= ~d[3];
      mask <= 4'hF;
   endtask
endmodule

`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the device-side command interface.
// Assumes the controller model drives all link pins; status on REF_CLK.
`include "ddr_cmd_map.svh"
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic sleep, cs_n, ras_n, cas_n, we_n, ac;
   logic [2:0] ba;
   logic [10:0] addr;
   logic [3:0] mask;
   logic [31:0] wdata, data_out;
   logic data_oe_n, strobe_oe_n, self_refresh, power_down, protocol_error;
   logic [9:0] mode_value, ext_mode_value;
   logic [7:0] bank_open;
   logic [3:0] strobe;
   logic [31:0] expect_word [4];
   int failures = 0;
   int samples_checked = 0;

   always #2 ref_clk = ~ref_clk;
   always #7.5 link_clk = ~link_clk;

   ddr_ctl_model ctl (.link_clk(link_clk), .sleep(sleep), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ac(ac), .ba(ba),
      .addr(addr), .mask(mask), .wdata(wdata));

   ddr_cmd_device DUT (.REF_CLK(ref_clk), .RESET(reset),
      .LINK_CLK(link_clk), .SLEEP(sleep), .CHIP_SELECT_N(cs_n),
      .ROW_STROBE_N(ras_n), .COLUMN_STROBE_N(cas_n),
      .WRITE_ENABLE_N(we_n), .AUTO_CLOSE(ac), .ARRAY_SEL(ba),
      .ADDRESS(addr), .BYTE_MASK(mask), .DATA_IN(wdata),
      .DATA_OUT(data_out), .DATA_OE_N(data_oe_n), .DATA_STROBE_OUT(strobe),
      .DATA_STROBE_OE_N(strobe_oe_n), .MODE_VALUE(mode_value),
      .EXT_MODE_VALUE(ext_mode_value), .BANK_OPEN(bank_open),
      .SELF_REFRESH(self_refresh), .POWER_DOWN(power_down),
      .PROTOCOL_ERROR(protocol_error));

   task automatic check(input string name, input logic [31:0] got,
         input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Status crosses to REF_CLK, so waits include the synchroniser
   task automatic links(input int n);
      repeat (n) @(posedge link_clk);
   endtask

   task automatic test_reset;
      check("mode", 32'(mode_value), 32'h032);
      check("ext mode", 32'(ext_mode_value), 32'h000);
      check("banks", 32'(bank_open), 32'h00);
      check("data drive", 32'(data_oe_n), 32'h1);
      check("error", 32'(protocol_error), 32'h0);
      $display("test reset done");
   endtask

   task automatic test_mode;
      ctl.cmd(4'h2, 1'b1, 3'h0, 11'h000, 1'b1);
      links(2);
      ctl.cmd(4'h0, 1'b0, 3'h1, 11'h155, 1'b1);
      links(4);
      check("ext mode", 32'(ext_mode_value), 32'h155);
      check("mode kept", 32'(mode_value), 32'h032);
      $display("test mode done");
   endtask

   task automatic test_write;
      logic [31:0] d [4];
      logic [31:0] w [4];
      logic [3:0] m [4];
      logic [3:0] none [4];
      for (int i = 0; i < 4; i++) begin
         d[i] = 32'h1111_1111 * (i + 1);
         w[i] = 32'hCAFE_0000 | 32'(i);
         m[i] = 4'h1 << i;
         none[i] = 4'h0;
         for (int j = 0; j < 4; j++) begin
            expect_word[i][8*j +: 8] = m[i][j] ? d[i][8*j +: 8]
               : w[i][8*j +: 8];
         end
      end
      ctl.cmd(4'h3, 1'b0, 3'h2, 11'h155, 1'b1);
      links(6);
      check("open", 32'(bank_open), 32'h04);
      ctl.cmd(4'h4, 1'b0, 3'h2, 11'h005, 1'b1);
      ctl.store_data(3, d, none);
      links(6);
      check("plain store end", 32'(bank_open), 32'h04);
      ctl.cmd(4'h4, 1'b1, 3'h2, 11'h005, 1'b1);
      ctl.store_data(3, w, m);
      links(6);
      check("autoclose store end", 32'(bank_open), 32'h00);
      $display("test write done");
   endtask

   task automatic test_read;
      ctl.cmd(4'h0, 1'b0, 3'h0, 11'h022, 1'b1);
      links(4);
      check("mode", 32'(mode_value), 32'h022);
      ctl.cmd(4'h3, 1'b0, 3'h2, 11'h7AA, 1'b1);
      links(6);
      ctl.cmd(4'h5, 1'b0, 3'h2, 11'h005, 1'b1);
      links(1);
      for (int i = 0; i < 4; i++) begin
         @(negedge link_clk);
         check("read word", data_out, expect_word[i]);
         check("read drive", 32'(data_oe_n), 32'h0);
         check("strobe drive", 32'(strobe_oe_n), 32'h0);
         check("strobe level", 32'(strobe),
            (i % 2 == 0) ? 32'hF : 32'h0);
         @(posedge link_clk);
      end
      @(negedge link_clk);
      check("read release", 32'(data_oe_n), 32'h1);
      check("strobe idle", 32'(strobe), 32'h0);
      links(6);
      check("plain read end", 32'(bank_open), 32'h04);
      $display("test read done");
   endtask

   task automatic test_close;
      ctl.cmd(4'h3, 1'b0, 3'h5, 11'h001, 1'b1);
      links(4);
      ctl.cmd(4'h2, 1'b0, 3'h2, 11'h000, 1'b1);
      links(6);
      check("single close", 32'(bank_open), 32'h20);
      ctl.cmd(4'h2, 1'b1, 3'h0, 11'h000, 1'b1);
      links(6);
      check("all close", 32'(bank_open), 32'h00);
      $display("test close done");
   endtask

   task automatic test_low_power;
      ctl.cmd(4'h1, 1'b0, 3'h0, 11'h000, 1'b1);
      links(10);
      ctl.cmd(4'h1, 1'b0, 3'h0, 11'h000, 1'b0);
      links(4);
      check("self entry", 32'(self_refresh), 32'h1);
      ctl.cmd(4'hF, 1'b0, 3'h0, 11'h000, 1'b1);
      links(20);
      check("self exit", 32'(self_refresh), 32'h0);
      ctl.cmd(4'h7, 1'b0, 3'h0, 11'h000, 1'b0);
      links(4);
      check("sleep entry", 32'(power_down), 32'h1);
      ctl.cmd(4'hF, 1'b0, 3'h0, 11'h000, 1'b1);
      links(6);
      check("sleep exit", 32'(power_down), 32'h0);
      check("no error", 32'(protocol_error), 32'h0);
      $display("test low power done");
   endtask

   // Refusal case: column command to an idle bank
   task automatic test_refused;
      ctl.cmd(4'h5, 1'b0, 3'h3, 11'h000, 1'b1);
      links(6);
      check("refused read", 32'(protocol_error), 32'h1);
      check("idle bank", 32'(data_oe_n), 32'h1);
      $display("test refused done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      links(4);
      test_reset;
      test_mode;
      test_write;
      test_read;
      test_close;
      test_low_power;
      test_refused;
      finish_test;
   end

   // Whole sequence takes about 160 link cycles
   initial begin
      #20000;
      failures++;
      finish_test;
   end
endmodule

`default_nettype wire
